// File: logic/csw_regs.sv
`timescale 1ns/100ps
`include "csw_map.svh"

module csw_regs (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire csw_pkg::csw_addr_t addr_in,
  input wire csw_pkg::csw_word_t wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic bus_reset_in,
  output csw_pkg::csw_word_t rd_data_out,
  output logic irq_out,
  output csw_pkg::csw_word_t bus_manager_id_out,
  output csw_pkg::csw_word_t bandwidth_avail_out,
  output csw_pkg::csw_word_t channels_hi_out,
  output csw_pkg::csw_word_t channels_lo_out
);
  import csw_pkg::*;

  function automatic logic addr_hit(input csw_addr_t a, input csw_addr_t off);
    addr_hit = (a == off);
  endfunction

  // resource select field of a control word
  function automatic csw_res_sel_t sel_field(input csw_word_t w);
    sel_field = csw_res_sel_t'(w[`CSW_CTRL_SEL_MSB:`CSW_CTRL_SEL_LSB]);
  endfunction

  // interrupt bits sit at the bottom of their word, the rest reads zero
  function automatic csw_word_t irq_word(input logic [`CSW_IRQ_WIDTH-1:0] v);
    irq_word = {{(32 - `CSW_IRQ_WIDTH){1'b0}}, v};
  endfunction

  // control word: flag on top, select at the bottom, bits between read zero
  function automatic csw_word_t ctrl_pack(input logic done, input csw_res_sel_t sel);
    ctrl_pack = `CSW_RST_WORD;
    ctrl_pack[`CSW_CTRL_DONE_BIT] = done;
    ctrl_pack[`CSW_CTRL_SEL_MSB:`CSW_CTRL_SEL_LSB] = sel;
  endfunction

  // bus reset pin comes from outside the clock domain
  logic bus_rst_meta_r;
  logic bus_rst_sync_r;
  logic bus_rst_prev_r;

  // first stage may go metastable; nothing but the second stage reads it
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      bus_rst_meta_r <= 1'b0;
    end else begin
      bus_rst_meta_r <= bus_reset_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      bus_rst_sync_r <= 1'b0;
    end else begin
      bus_rst_sync_r <= bus_rst_meta_r;
    end
  end

  // history resets to the idle level of the pin, so no false edge follows reset
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      bus_rst_prev_r <= 1'b0;
    end else begin
      bus_rst_prev_r <= bus_rst_sync_r;
    end
  end

  wire logic bus_rst_rise = bus_rst_sync_r & ~bus_rst_prev_r;

  // address decode
  wire logic hit_data = addr_hit(addr_in, `CSW_OFF_SWAP_DATA);
  wire logic hit_cmp = addr_hit(addr_in, `CSW_OFF_SWAP_CMP);
  wire logic hit_ctrl = addr_hit(addr_in, `CSW_OFF_SWAP_CTRL);
  wire logic hit_stat = addr_hit(addr_in, `CSW_OFF_IRQ_STATUS);
  wire logic hit_mask = addr_hit(addr_in, `CSW_OFF_IRQ_MASK);

  wire logic wr_data = wr_en_in & hit_data;
  wire logic wr_cmp = wr_en_in & hit_cmp;
  wire logic wr_ctrl = wr_en_in & hit_ctrl;
  wire logic wr_mask = wr_en_in & hit_mask;
  wire logic rd_stat = rd_en_in & hit_stat;
  wire logic hit_any = hit_data | hit_cmp | hit_ctrl | hit_stat | hit_mask;
  wire logic rd_take = rd_en_in & hit_any;

  // swap engine handshake
  logic eng_busy;
  logic eng_done;
  logic eng_match;
  csw_word_t eng_old;
  csw_word_t eng_res [4];

  // a control write while an operation runs only clears the flag
  wire logic start_swap = wr_ctrl & ~eng_busy;

  // swap operand registers
  csw_word_t swap_data_r;
  csw_word_t swap_data_nxt;
  csw_word_t swap_cmp_r;
  csw_word_t swap_cmp_nxt;
  csw_res_sel_t sel_r;
  csw_res_sel_t sel_nxt;
  logic done_r;
  logic done_nxt;

  // after completion the data register reports the value found in the resource
  assign swap_data_nxt = eng_done ? eng_old : (wr_data ? wr_data_in : swap_data_r);
  assign swap_cmp_nxt = wr_cmp ? wr_data_in : swap_cmp_r;
  // select only follows a write that really starts an operation
  assign sel_nxt = start_swap ? sel_field(wr_data_in) : sel_r;
  // completion beats a simultaneous clearing write
  assign done_nxt = eng_done ? 1'b1 : (wr_ctrl ? 1'b0 : done_r);

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      swap_data_r <= `CSW_RST_WORD;
    end else begin
      swap_data_r <= swap_data_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      swap_cmp_r <= `CSW_RST_WORD;
    end else begin
      swap_cmp_r <= swap_cmp_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sel_r <= csw_res_sel_t'(`CSW_RST_CTRL_SEL);
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // the flag comes out of reset set, as no operation is outstanding
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      done_r <= `CSW_RST_CTRL_DONE;
    end else begin
      done_r <= done_nxt;
    end
  end

  csw_swap_unit u_swap (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .start_in(start_swap),
    .sel_in(sel_field(wr_data_in)),
    .cmp_in(swap_cmp_r),
    .data_in(swap_data_r),
    .bus_reset_in(bus_rst_rise),
    .busy_out(eng_busy),
    .done_out(eng_done),
    .match_out(eng_match),
    .old_out(eng_old),
    .res_out(eng_res)
  );

  // interrupt events: done, compare failed, bus reset seen
  logic [`CSW_IRQ_WIDTH-1:0] irq_events;
  logic [`CSW_IRQ_WIDTH-1:0] irq_status;
  logic [`CSW_IRQ_WIDTH-1:0] irq_mask;
  logic irq_line;

  assign irq_events[`CSW_IRQ_DONE_BIT] = eng_done;
  assign irq_events[`CSW_IRQ_FAIL_BIT] = eng_done & ~eng_match;
  assign irq_events[`CSW_IRQ_BUSRST_BIT] = bus_rst_rise;

  csw_irq_unit #(
    .WIDTH(`CSW_IRQ_WIDTH)
  ) u_irq (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .event_in(irq_events),
    .clear_in(rd_stat),
    .mask_wr_in(wr_mask),
    .mask_in(wr_data_in[`CSW_IRQ_WIDTH-1:0]),
    .status_out(irq_status),
    .mask_out(irq_mask),
    .irq_out(irq_line)
  );

  // one word per readable register
  wire csw_word_t data_word = swap_data_r;
  wire csw_word_t cmp_word = swap_cmp_r;
  wire csw_word_t ctrl_word = ctrl_pack(done_r, sel_r);
  wire csw_word_t stat_word = irq_word(irq_status);
  wire csw_word_t mask_word = irq_word(irq_mask);

  // offsets are distinct, so at most one select is high and an or-tree suffices
  wire csw_word_t rd_mux =
      ({32{hit_data}} & data_word) |
      ({32{hit_cmp}} & cmp_word) |
      ({32{hit_ctrl}} & ctrl_word) |
      ({32{hit_stat}} & stat_word) |
      ({32{hit_mask}} & mask_word);

  csw_word_t rd_data_r;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rd_data_r <= `CSW_RST_WORD;
    end else begin
      rd_data_r <= rd_take ? rd_mux : 32'h0000_0000;
    end
  end

  assign rd_data_out = rd_data_r;
  assign irq_out = irq_line;
  assign bus_manager_id_out = eng_res[CSW_RES_BM_ID];
  assign bandwidth_avail_out = eng_res[CSW_RES_BW_AVAIL];
  assign channels_hi_out = eng_res[CSW_RES_CH_HI];
  assign channels_lo_out = eng_res[CSW_RES_CH_LO];
endmodule

// File: logic/csw_map.svh
`ifndef CSW_MAP_SVH
`define CSW_MAP_SVH

// register byte offsets
`define CSW_OFF_SWAP_DATA 8'h0C
`define CSW_OFF_SWAP_CMP 8'h10
`define CSW_OFF_SWAP_CTRL 8'h14
`define CSW_OFF_IRQ_STATUS 8'h40
`define CSW_OFF_IRQ_MASK 8'h44

// swap_control fields
`define CSW_CTRL_DONE_BIT 31
`define CSW_CTRL_SEL_LSB 0
`define CSW_CTRL_SEL_MSB 1

// interrupt status / mask fields
`define CSW_IRQ_DONE_BIT 0
`define CSW_IRQ_FAIL_BIT 1
`define CSW_IRQ_BUSRST_BIT 2
`define CSW_IRQ_WIDTH 3

// reset values
`define CSW_RST_CTRL_DONE 1'b1
`define CSW_RST_CTRL_SEL 2'h0
`define CSW_RST_WORD 32'h0000_0000
`define CSW_RST_IRQ_MASK 3'h0
`define CSW_RST_BM_ID 32'h0000_003F
`define CSW_RST_BW_AVAIL 32'h0000_1333
`define CSW_RST_CH_HI 32'hFFFF_FFFF
`define CSW_RST_CH_LO 32'hFFFF_FFFF

`endif

// File: logic/csw_pkg.sv
package csw_pkg;
  typedef logic [31:0] csw_word_t;
  typedef logic [7:0] csw_addr_t;

  typedef enum logic [1:0] {
    CSW_RES_BM_ID = 2'b00,
    CSW_RES_BW_AVAIL = 2'b01,
    CSW_RES_CH_HI = 2'b10,
    CSW_RES_CH_LO = 2'b11
  } csw_res_sel_t;

  typedef enum logic [1:0] {
    CSW_ST_IDLE = 2'b00,
    CSW_ST_FETCH = 2'b01,
    CSW_ST_STORE = 2'b10
  } csw_state_t;
endpackage

// File: logic/csw_swap_unit.sv
`timescale 1ns/100ps
`include "csw_map.svh"

// holds the four bus-management resources and performs one compare-swap at a time
module csw_swap_unit (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire csw_pkg::csw_res_sel_t sel_in,
  input wire csw_pkg::csw_word_t cmp_in,
  input wire csw_pkg::csw_word_t data_in,
  input wire logic bus_reset_in,
  output logic busy_out,
  output logic done_out,
  output logic match_out,
  output csw_pkg::csw_word_t old_out,
  output csw_pkg::csw_word_t res_out [4]
);
  import csw_pkg::*;

  csw_state_t state_r;
  csw_state_t state_nxt;
  csw_res_sel_t sel_r;
  csw_word_t cmp_r;
  csw_word_t data_r;
  csw_word_t res_r [4];
  logic done_r;
  logic match_r;
  csw_word_t old_r;

  wire csw_word_t cur_val = res_r[sel_r];
  wire logic cmp_hit = (cur_val == cmp_r);
  wire logic do_store = (state_r == CSW_ST_STORE) && match_r;

  always_comb begin
    unique case (state_r)
      CSW_ST_IDLE: state_nxt = start_in ? CSW_ST_FETCH : CSW_ST_IDLE;
      CSW_ST_FETCH: state_nxt = CSW_ST_STORE;
      CSW_ST_STORE: state_nxt = CSW_ST_IDLE;
      default: state_nxt = CSW_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_r <= CSW_ST_IDLE;
      sel_r <= CSW_RES_BM_ID;
      cmp_r <= `CSW_RST_WORD;
      data_r <= `CSW_RST_WORD;
      done_r <= 1'b0;
      match_r <= 1'b0;
      old_r <= `CSW_RST_WORD;
    end else begin
      state_r <= state_nxt;
      done_r <= (state_r == CSW_ST_STORE);
      if (state_r == CSW_ST_IDLE && start_in) begin
        sel_r <= sel_in;
        cmp_r <= cmp_in;
        data_r <= data_in;
      end
      if (state_r == CSW_ST_FETCH) begin
        old_r <= cur_val;
        match_r <= cmp_hit;
      end
    end
  end

  // a bus reset restores the resources; an operation finishing alongside it is dropped
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || bus_reset_in) begin
      res_r[0] <= `CSW_RST_BM_ID;
      res_r[1] <= `CSW_RST_BW_AVAIL;
      res_r[2] <= `CSW_RST_CH_HI;
      res_r[3] <= `CSW_RST_CH_LO;
    end else if (do_store) begin
      res_r[sel_r] <= data_r;
    end
  end

  assign busy_out = (state_r != CSW_ST_IDLE);
  assign done_out = done_r;
  assign match_out = match_r;
  assign old_out = old_r;
  assign res_out = res_r;
endmodule

// File: logic/csw_irq_unit.sv
`timescale 1ns/100ps
`include "csw_map.svh"

// sticky event bits, cleared by a read; a new event beats the clear
module csw_irq_unit #(
  parameter int WIDTH = `CSW_IRQ_WIDTH
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic clear_in,
  input wire logic mask_wr_in,
  input wire logic [WIDTH-1:0] mask_in,
  output logic [WIDTH-1:0] status_out,
  output logic [WIDTH-1:0] mask_out,
  output logic irq_out
);
  logic [WIDTH-1:0] status_r;
  logic [WIDTH-1:0] mask_r;
  logic irq_r;

  wire logic [WIDTH-1:0] status_nxt = (clear_in ? '0 : status_r) | event_in;
  wire logic [WIDTH-1:0] mask_nxt = mask_wr_in ? mask_in : mask_r;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      status_r <= '0;
      mask_r <= WIDTH'(`CSW_RST_IRQ_MASK);
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  assign status_out = status_r;
  assign mask_out = mask_r;
  assign irq_out = irq_r;
endmodule

// File: sim/csw_regs_sva.sv
`timescale 1ns/100ps
`include "csw_map.svh"
module csw_regs_sva (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire csw_pkg::csw_addr_t addr_in,
  input wire csw_pkg::csw_word_t wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire csw_pkg::csw_word_t rd_data_out,
  input wire csw_pkg::csw_word_t bus_manager_id_out,
  input wire csw_pkg::csw_word_t channels_lo_out
);
  import csw_pkg::*;
  csw_word_t cmp_r;
  csw_word_t data_r;
  wire ctl_wr = wr_en_in && addr_in == `CSW_OFF_SWAP_CTRL;
  wire ctl_rd = rd_en_in && addr_in == `CSW_OFF_SWAP_CTRL;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in && addr_in == `CSW_OFF_SWAP_CMP)
      cmp_r <= wr_data_in;
    if (wr_en_in && addr_in == `CSW_OFF_SWAP_DATA)
      data_r <= wr_data_in;
  end
  a_rsvd_zero: assert property (ctl_rd |=> rd_data_out[30:2] == 29'h0)
    else $error("reserved control bits set");
  a_done_clear: assert property (ctl_wr ##2 ctl_rd |=> !rd_data_out[31])
    else $error("done survives control write");
  a_done_early: assert property (ctl_wr ##3 ctl_rd |=> !rd_data_out[31])
    else $error("done too early");
  a_done_late: assert property (ctl_wr ##4 ctl_rd |=> rd_data_out[31]
    && rd_data_out[1:0] == $past(wr_data_in[1:0], 5)) else $error("done or select wrong");
  a_store_match: assert property (ctl_wr && wr_data_in[1:0] == 2'b00
    && bus_manager_id_out == cmp_r |-> ##[2:4] bus_manager_id_out == data_r)
    else $error("matching swap not stored");
  a_keep_miss: assert property (ctl_wr && wr_data_in[1:0] == 2'b11
    && channels_lo_out != cmp_r |=> $stable(channels_lo_out) [*4])
    else $error("mismatching swap stored");
  a_idle_zero: assert property (!rd_en_in |=> rd_data_out == 32'h0)
    else $error("read data outside read");
  a_unmapped_zero: assert property (
    rd_en_in && addr_in == 8'h08 |=> rd_data_out == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind csw_regs csw_regs_sva u_sva (.clk_sys_in, .sys_rst_in, .addr_in, .wr_data_in, .wr_en_in,
  .rd_en_in, .rd_data_out, .bus_manager_id_out, .channels_lo_out);

// File: sim/tb_top.sv
`timescale 1ns/100ps
`include "csw_map.svh"
module tb_top;
  import csw_pkg::*;
  logic clk_sys_in = 0;
  logic sys_rst_in = 1;
  logic wr_en_in = 0;
  logic rd_en_in = 0;
  logic bus_reset_in = 0;
  logic irq_out;
  logic [1:0] s;
  logic [2:0] st = 3'h0;
  logic [2:0] msk;
  csw_addr_t addr_in = 8'h00;
  csw_word_t wr_data_in = 32'h0;
  csw_word_t rd_data_out, cmpv, datv, old, r;
  csw_word_t expq [$];
  csw_word_t res_out [4];
  csw_word_t rst_v [4] = '{`CSW_RST_BM_ID, `CSW_RST_BW_AVAIL, `CSW_RST_CH_HI, `CSW_RST_CH_LO};
  csw_word_t res [4];
  int failures = 0;
  int cmp_count = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  csw_regs dut (.clk_sys_in, .sys_rst_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
    .bus_reset_in, .rd_data_out, .irq_out, .bus_manager_id_out(res_out[0]),
    .bandwidth_avail_out(res_out[1]), .channels_hi_out(res_out[2]),
    .channels_lo_out(res_out[3]));
  task automatic chk(csw_word_t seen, csw_word_t exp, string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one bus cycle; a read issued here is checked one call later
  task automatic cyc(logic w, logic rd, csw_addr_t a, csw_word_t d, csw_word_t e);
    @(posedge clk_sys_in);
    wr_en_in <= w;
    rd_en_in <= rd;
    addr_in <= a;
    wr_data_in <= d;
    #1 if (expq.size() > 0) chk(rd_data_out, expq.pop_front(), "rd_data");
    if (rd) expq.push_back(e);
  endtask
  task automatic res_chk();
    for (int k = 0; k < 4; k++) chk(res_out[k], res[k], "resource");
  endtask
  initial begin
    #20000;
    failures++;
    stop_test();
  end
  initial begin
    void'($urandom(41372));
    res = rst_v;
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 0;
    cyc(0, 1, `CSW_OFF_SWAP_CTRL, 0, 32'h8000_0000);
    cyc(0, 1, 8'h08, 0, 0);
    cyc(0, 0, 0, 0, 0);
    res_chk();
    for (int i = 0; i < 8; i++) begin
      s = i[1:0];
      msk = 3'($urandom);
      cmpv = i[2] ? ~res[s] : res[s];
      datv = $urandom;
      r = $urandom;
      r[1:0] = s;
      cyc(1, 0, `CSW_OFF_IRQ_MASK, {29'h0, msk}, 0);
      cyc(1, 0, `CSW_OFF_SWAP_CMP, cmpv, 0);
      cyc(1, 0, `CSW_OFF_SWAP_DATA, datv, 0);
      cyc(0, 1, `CSW_OFF_SWAP_CMP, 0, cmpv);
      cyc(1, 0, `CSW_OFF_SWAP_CTRL, r, 0);
      cyc(0, 0, 0, 0, 0);
      cyc(0, 1, `CSW_OFF_SWAP_CTRL, 0, {30'h0, s});
      cyc(0, 1, `CSW_OFF_SWAP_CTRL, 0, {30'h0, s});
      old = res[s];
      if (old === cmpv) res[s] = datv;
      st = st | {1'b0, old !== cmpv, 1'b1};
      cyc(0, 1, `CSW_OFF_SWAP_CTRL, 0, {1'b1, 29'h0, s});
      cyc(0, 1, `CSW_OFF_SWAP_DATA, 0, old);
      res_chk();
      chk({31'h0, irq_out}, {31'h0, |(st & msk)}, "irq");
      cyc(0, 1, `CSW_OFF_IRQ_STATUS, 0, {29'h0, st});
      st = 3'h0;
      repeat (3) cyc(0, 0, 0, 0, 0);
      chk({31'h0, irq_out}, 32'h0, "irq clear");
    end
    @(posedge clk_sys_in);
    bus_reset_in <= 1;
    repeat (8) cyc(0, 0, 0, 0, 0);
    res = rst_v;
    res_chk();
    cyc(0, 1, `CSW_OFF_IRQ_STATUS, 0, 32'h4);
    cyc(0, 0, 0, 0, 0);
    stop_test();
  end
endmodule
